/* File: hdl/tffc_defs.svh */
// Register indices, reset values and bus constants for the framing config bank
`ifndef TFFC_DEFS_SVH
`define TFFC_DEFS_SVH

`define TFFC_IDX_WIDTH 7
`define TFFC_IDX_LINE_CODE 7'h10
`define TFFC_IDX_FRAMER 7'h20
`define TFFC_IDX_BOC_ENABLE 7'h2a
`define TFFC_IDX_ALARM 7'h2c
`define TFFC_IDX_INBAND 7'h3c
`define TFFC_IDX_ACTIVATE 7'h3e
`define TFFC_IDX_DEACTIVATE 7'h3f
`define TFFC_IDX_SIGNALLING 7'h40
`define TFFC_IDX_TX_FORMAT 7'h44
`define TFFC_IDX_SOFT_RESET 7'h0a
`define TFFC_IDX_STATUS 7'h0b
`define TFFC_IDX_TIMING_DIAG 7'h0d

`define TFFC_RST_CONFIG 8'h00
`define TFFC_RST_ACTIVATE 8'h08
`define TFFC_RST_DEACTIVATE 8'h44
`define TFFC_RST_TIMING_DIAG 8'h03

`define TFFC_BIT_SOFT_RESET 0
`define TFFC_BIT_JITTER_ATTEN 0
`define TFFC_BIT_TX_CLK_BACKPLANE 1
`define TFFC_BIT_DIAG_ENABLE 2
`define TFFC_BIT_LINE_AMI 7
`define TFFC_BIT_TX_B8ZS 5
`define TFFC_BIT_ESF 4
`define TFFC_BIT_BOC_4OF5 1
`define TFFC_BIT_ALT_RED 3
`define TFFC_BIT_NO_ROBBED 2

`endif

/* File: hdl/tffc_pkg.sv */
// Types shared by the framing configuration bank
package tffc_pkg;
	typedef enum logic [1:0] {
		FMT_SF,
		FMT_T1DM,
		FMT_LOOP_CARRIER,
		FMT_ESF
	} tffc_format_type;

	typedef enum logic [1:0] {
		OOF_2_OF_4,
		OOF_2_OF_5,
		OOF_2_OF_6,
		OOF_RESERVED
	} tffc_oof_type;
endpackage : tffc_pkg

/* File: hdl/tffc_mode_decode.sv */
// Decodes configuration register values into per-unit mode settings
`timescale 1ns/1ps
`include "tffc_defs.svh"

module tffc_mode_decode (
	// Register values
	input wire logic [7:0] lineCodeCfg,
	input wire logic [7:0] framerCfg,
	input wire logic [7:0] bocCfg,
	input wire logic [7:0] alarmCfg,
	input wire logic [7:0] inbandCfg,
	input wire logic [7:0] signalCfg,
	input wire logic [7:0] txFormatCfg,
	// Decoded modes
	output tffc_pkg::tffc_format_type rxFormat,
	output tffc_pkg::tffc_oof_type oofThreshold,
	output logic rxB8zs,
	output tffc_pkg::tffc_format_type txFormat,
	output logic txB8zs,
	output logic bocFourOfFive,
	output tffc_pkg::tffc_format_type alarmFormat,
	output logic alarmAltRed,
	output logic inbandEnable,
	output tffc_pkg::tffc_format_type sigFormat,
	output logic robbedBitEnable,
	output logic rateMismatch
);
	import tffc_pkg::*;

	// ESF flag wins; otherwise bits 3:2 give SF, T1DM or loop carrier
	function automatic tffc_format_type fmtDecode(input logic [7:0] v);
		tffc_format_type f;
		if (v[`TFFC_BIT_ESF]) begin
			f = FMT_ESF;
		end else begin
			case (v[3:2])
				2'h0: f = FMT_SF;
				2'h2: f = FMT_LOOP_CARRIER;
				default: f = FMT_T1DM;
			endcase
		end
		return f;
	endfunction : fmtDecode

	always_comb begin
		rxB8zs = ~lineCodeCfg[`TFFC_BIT_LINE_AMI];
		txB8zs = txFormatCfg[`TFFC_BIT_TX_B8ZS];
		txFormat = fmtDecode(txFormatCfg);
		oofThreshold = tffc_oof_type'(framerCfg[7:6]);
		rxFormat = fmtDecode(framerCfg);
		bocFourOfFive = bocCfg[`TFFC_BIT_BOC_4OF5];
		alarmFormat = fmtDecode(alarmCfg);
		alarmAltRed = (alarmFormat == FMT_T1DM)
			&& alarmCfg[`TFFC_BIT_ALT_RED];
		inbandEnable = (inbandCfg == `TFFC_RST_CONFIG);
		sigFormat = fmtDecode(signalCfg);
		robbedBitEnable = (sigFormat != FMT_T1DM);
		// Software should keep the ESF rate nibbles equal across units
		rateMismatch = (rxFormat == FMT_ESF) && (
			(txFormat == FMT_ESF && txFormatCfg[3:0] != framerCfg[3:0])
			|| (alarmFormat == FMT_ESF && alarmCfg[3:0] != framerCfg[3:0])
			|| (sigFormat == FMT_ESF && signalCfg[3:0] != framerCfg[3:0]));
	end
endmodule : tffc_mode_decode

/* File: hdl/tffc_config_bank.sv */
// Framing format configuration register bank with Avalon-MM slave
// What this block does
// - Line code register 0x10: 0x00 selects B8ZS receive, 0x80 AMI.
// - Transmit format 0x44 written 0x00 gives AMI with SF framing.
// - Transmit value 0x3X gives B8ZS with ESF; X sets link rate.
// - Transmit 0x04 or 0x0C gives T1DM; 0x08 gives loop carrier.
// - Framer 0x20 upper bits set out-of-frame threshold 2/4, 2/5, 2/6.
// - Framer low bits select SF, T1DM, loop carrier or ESF receive.
// - Code detector enable 0x2A: 0x00 is 8-of-10, 0x02 4-of-5.
// - Alarm 0x2C selects SF, loop carrier or ESF with yellow rate.
// - Alarm 0x04 standard, 0x0C alternate red integration for T1DM.
// - Inband detector config 0x3C written 0x00 enables code detection.
// - Activate pattern at 0x3E and deactivate pattern at 0x3F.
// - Signalling config 0x40 selects SF, loop carrier or ESF.
// - Signalling value 0x04 disables robbed-bit extraction for T1DM.
// - Pin or software reset returns all settings to defaults.
`timescale 1ns/1ps
`include "tffc_defs.svh"

module tffc_config_bank #(
	parameter int REG_WIDTH = 8,
	parameter int ADDR_WIDTH = 9
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Avalon-MM slave
	input wire logic [ADDR_WIDTH-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Receive side modes
	output logic rxB8zs,
	output tffc_pkg::tffc_format_type rxFormat,
	output tffc_pkg::tffc_oof_type oofThreshold,
	output logic [3:0] rxLinkRate,
	// Transmit side modes
	output tffc_pkg::tffc_format_type txFormat,
	output logic txB8zs,
	output logic [3:0] txLinkRate,
	// Code detectors and alarms
	output logic bocFourOfFive,
	output tffc_pkg::tffc_format_type alarmFormat,
	output logic alarmAltRed,
	output logic [3:0] yellowRate,
	output logic inbandEnable,
	output logic [7:0] loopActivatePattern,
	output logic [7:0] loopDeactivatePattern,
	// Signalling extractor
	output tffc_pkg::tffc_format_type sigFormat,
	output logic robbedBitEnable,
	output logic [3:0] sigRate,
	// Timing and diagnostics
	output logic jitterAttenEnable,
	output logic txClockFromBackplane,
	output logic diagnosticsEnable,
	output logic rateMismatch
);
	import tffc_pkg::*;

	// Refuse widths that the byte-wide decode cannot serve
	if (REG_WIDTH != 8) begin : gRegWidth
		$error("tffc_config_bank: REG_WIDTH must be 8");
	end
	if (ADDR_WIDTH < `TFFC_IDX_WIDTH + 2) begin : gAddrWidth
		$error("tffc_config_bank: ADDR_WIDTH too small");
	end

	// Configuration registers
	logic [7:0] lineCode_q, lineCode_d;
	logic [7:0] framer_q, framer_d;
	logic [7:0] boc_q, boc_d;
	logic [7:0] alarm_q, alarm_d;
	logic [7:0] inband_q, inband_d;
	logic [7:0] activate_q, activate_d;
	logic [7:0] deactivate_q, deactivate_d;
	logic [7:0] signal_q, signal_d;
	logic [7:0] txFmt_q, txFmt_d;
	logic [7:0] timing_q, timing_d;

	// Bus handshake state
	logic wait_q, wait_d;
	logic [31:0] rdata_q, rdata_d;

	// Decoded modes, combinational then registered for the outputs
	tffc_format_type rxFormatC, txFormatC, alarmFormatC, sigFormatC;
	tffc_oof_type oofC;
	logic rxB8zsC, txB8zsC, bocC, altRedC, inbandC, robbedC, mismatchC;

	tffc_format_type rxFormat_q, txFormat_q, alarmFormat_q, sigFormat_q;
	tffc_oof_type oof_q;
	logic rxB8zs_q, txB8zs_q, boc_o_q, altRed_q, inband_o_q;
	logic robbed_q, mismatch_q;

	logic [`TFFC_IDX_WIDTH-1:0] idx;
	logic access;
	logic commit;
	logic wrCommit;
	logic softReset;
	logic [7:0] wbyte;
	logic [7:0] status;

	// Registers sit on word boundaries; only byte lane 0 carries data
	assign idx = address[`TFFC_IDX_WIDTH+1:2];
	assign access = read | write;
	// Request completes in the cycle waitrequest is low
	assign commit = access & ~wait_q;
	assign wrCommit = commit & write & byteenable[0];
	assign wbyte = writedata[7:0];
	// Software reset is a write-only pulse and reads back as zero
	assign softReset = wrCommit && idx == `TFFC_IDX_SOFT_RESET
		&& wbyte[`TFFC_BIT_SOFT_RESET];
	// Status lags the registers by a cycle, like the decoded outputs
	assign status = {mismatch_q, 1'b0, rxFormat_q, txFormat_q, sigFormat_q};

	tffc_mode_decode tffc_mode_decode_inst (
		.lineCodeCfg(lineCode_q),
		.framerCfg(framer_q),
		.bocCfg(boc_q),
		.alarmCfg(alarm_q),
		.inbandCfg(inband_q),
		.signalCfg(signal_q),
		.txFormatCfg(txFmt_q),
		.rxFormat(rxFormatC),
		.oofThreshold(oofC),
		.rxB8zs(rxB8zsC),
		.txFormat(txFormatC),
		.txB8zs(txB8zsC),
		.bocFourOfFive(bocC),
		.alarmFormat(alarmFormatC),
		.alarmAltRed(altRedC),
		.inbandEnable(inbandC),
		.sigFormat(sigFormatC),
		.robbedBitEnable(robbedC),
		.rateMismatch(mismatchC)
	);

	// Unmapped indices read as zero
	function automatic logic [7:0] regRead(input logic [6:0] i,
		input logic [7:0] st);
		logic [7:0] v;
		case (i)
			`TFFC_IDX_LINE_CODE: v = lineCode_q;
			`TFFC_IDX_FRAMER: v = framer_q;
			`TFFC_IDX_BOC_ENABLE: v = boc_q;
			`TFFC_IDX_ALARM: v = alarm_q;
			`TFFC_IDX_INBAND: v = inband_q;
			`TFFC_IDX_ACTIVATE: v = activate_q;
			`TFFC_IDX_DEACTIVATE: v = deactivate_q;
			`TFFC_IDX_SIGNALLING: v = signal_q;
			`TFFC_IDX_TX_FORMAT: v = txFmt_q;
			`TFFC_IDX_TIMING_DIAG: v = timing_q;
			`TFFC_IDX_STATUS: v = st;
			default: v = 8'h00;
		endcase
		return v;
	endfunction : regRead

	// Bus handshake: one wait cycle, then a single-cycle completion
	always_comb begin
		wait_d = 1'b1;
		rdata_d = rdata_q;
		if (access && wait_q) begin
			wait_d = 1'b0;
			// A completed write clears readdata so no stale value lingers
			rdata_d = read ? {24'h000000, regRead(idx, status)} : 32'h00000000;
		end
	end

	// Register writes
	always_comb begin
		lineCode_d = lineCode_q;
		framer_d = framer_q;
		boc_d = boc_q;
		alarm_d = alarm_q;
		inband_d = inband_q;
		activate_d = activate_q;
		deactivate_d = deactivate_q;
		signal_d = signal_q;
		txFmt_d = txFmt_q;
		timing_d = timing_q;
		// Software reset restores every register, timing options included
		if (softReset) begin
			lineCode_d = `TFFC_RST_CONFIG;
			framer_d = `TFFC_RST_CONFIG;
			boc_d = `TFFC_RST_CONFIG;
			alarm_d = `TFFC_RST_CONFIG;
			inband_d = `TFFC_RST_CONFIG;
			activate_d = `TFFC_RST_ACTIVATE;
			deactivate_d = `TFFC_RST_DEACTIVATE;
			signal_d = `TFFC_RST_CONFIG;
			txFmt_d = `TFFC_RST_CONFIG;
			timing_d = `TFFC_RST_TIMING_DIAG;
		end else if (wrCommit) begin
			case (idx)
				`TFFC_IDX_LINE_CODE: lineCode_d = wbyte;
				`TFFC_IDX_FRAMER: framer_d = wbyte;
				`TFFC_IDX_BOC_ENABLE: boc_d = wbyte;
				`TFFC_IDX_ALARM: alarm_d = wbyte;
				`TFFC_IDX_INBAND: inband_d = wbyte;
				`TFFC_IDX_ACTIVATE: activate_d = wbyte;
				`TFFC_IDX_DEACTIVATE: deactivate_d = wbyte;
				`TFFC_IDX_SIGNALLING: signal_d = wbyte;
				`TFFC_IDX_TX_FORMAT: txFmt_d = wbyte;
				`TFFC_IDX_TIMING_DIAG: timing_d = wbyte;
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			wait_q <= 1'b1;
			rdata_q <= 32'h00000000;
			lineCode_q <= `TFFC_RST_CONFIG;
			framer_q <= `TFFC_RST_CONFIG;
			boc_q <= `TFFC_RST_CONFIG;
			alarm_q <= `TFFC_RST_CONFIG;
			inband_q <= `TFFC_RST_CONFIG;
			activate_q <= `TFFC_RST_ACTIVATE;
			deactivate_q <= `TFFC_RST_DEACTIVATE;
			signal_q <= `TFFC_RST_CONFIG;
			txFmt_q <= `TFFC_RST_CONFIG;
			timing_q <= `TFFC_RST_TIMING_DIAG;
		end else begin
			wait_q <= wait_d;
			rdata_q <= rdata_d;
			lineCode_q <= lineCode_d;
			framer_q <= framer_d;
			boc_q <= boc_d;
			alarm_q <= alarm_d;
			inband_q <= inband_d;
			activate_q <= activate_d;
			deactivate_q <= deactivate_d;
			signal_q <= signal_d;
			txFmt_q <= txFmt_d;
			timing_q <= timing_d;
		end
	end

	// Output flops for decoded modes, one cycle after the register
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			rxFormat_q <= FMT_SF;
			txFormat_q <= FMT_SF;
			alarmFormat_q <= FMT_SF;
			sigFormat_q <= FMT_SF;
			oof_q <= OOF_2_OF_4;
			rxB8zs_q <= 1'b1;
			txB8zs_q <= 1'b0;
			boc_o_q <= 1'b0;
			altRed_q <= 1'b0;
			inband_o_q <= 1'b1;
			robbed_q <= 1'b1;
			mismatch_q <= 1'b0;
		end else begin
			rxFormat_q <= rxFormatC;
			txFormat_q <= txFormatC;
			alarmFormat_q <= alarmFormatC;
			sigFormat_q <= sigFormatC;
			oof_q <= oofC;
			rxB8zs_q <= rxB8zsC;
			txB8zs_q <= txB8zsC;
			boc_o_q <= bocC;
			altRed_q <= altRedC;
			inband_o_q <= inbandC;
			robbed_q <= robbedC;
			mismatch_q <= mismatchC;
		end
	end

	// Raw fields come straight from the register flops
	assign readdata = rdata_q;
	assign waitrequest = wait_q;
	assign rxB8zs = rxB8zs_q;
	assign rxFormat = rxFormat_q;
	assign oofThreshold = oof_q;
	assign rxLinkRate = framer_q[3:0];
	assign txFormat = txFormat_q;
	assign txB8zs = txB8zs_q;
	assign txLinkRate = txFmt_q[3:0];
	assign bocFourOfFive = boc_o_q;
	assign alarmFormat = alarmFormat_q;
	assign alarmAltRed = altRed_q;
	assign yellowRate = alarm_q[3:0];
	assign inbandEnable = inband_o_q;
	assign loopActivatePattern = activate_q;
	assign loopDeactivatePattern = deactivate_q;
	assign sigFormat = sigFormat_q;
	assign robbedBitEnable = robbed_q;
	assign sigRate = signal_q[3:0];
	assign jitterAttenEnable = timing_q[`TFFC_BIT_JITTER_ATTEN];
	assign txClockFromBackplane = timing_q[`TFFC_BIT_TX_CLK_BACKPLANE];
	assign diagnosticsEnable = timing_q[`TFFC_BIT_DIAG_ENABLE];
	assign rateMismatch = mismatch_q;
endmodule : tffc_config_bank

/* File: bench/tffc_config_monitor.sv */
// Port-level assertions for the framing configuration bank
`timescale 1ns/1ps
module tffc_config_monitor
	import tffc_pkg::*;
#(
	parameter int ADDR_WIDTH = 9
) (
	// Clock, reset and bus
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [ADDR_WIDTH-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	input wire logic waitrequest,
	// Modes
	input wire logic rxB8zs,
	input wire logic txB8zs,
	input wire logic bocFourOfFive,
	input tffc_pkg::tffc_format_type rxFormat,
	input tffc_pkg::tffc_format_type txFormat,
	input tffc_pkg::tffc_oof_type oofThreshold,
	input wire logic [7:0] loopActivatePattern,
	input wire logic jitterAttenEnable,
	input wire logic txClockFromBackplane,
	input wire logic diagnosticsEnable
);
	logic wrOk;
	logic [6:0] idx;
	always_comb begin
		wrOk = write && !waitrequest && byteenable[0];
		idx = address[8:2];
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	chk_wait_answer: assert property ((read || write) && waitrequest
		|=> !waitrequest) else $error("request not answered in one cycle");
	chk_wait_pulse: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low for more than one cycle");
	chk_wait_idle: assert property (!read && !write && waitrequest
		|=> waitrequest) else $error("waitrequest low without request");
	chk_reset_modes: assert property ($rose(reset_n) |-> rxB8zs &&
		!txB8zs && rxFormat == FMT_SF && txFormat == FMT_SF)
		else $error("modes not at defaults after reset");
	chk_reset_timing: assert property ($rose(reset_n) |->
		jitterAttenEnable && txClockFromBackplane && !diagnosticsEnable)
		else $error("timing options not at defaults after reset");
	chk_rx_code: assert property (wrOk && idx == 7'h10 |-> ##2
		rxB8zs == !$past(writedata[7], 2)) else $error("line code wrong");
	chk_rx_esf: assert property (wrOk && idx == 7'h20 && writedata[4]
		|-> ##2 rxFormat == FMT_ESF) else $error("framer not in ESF");
	chk_oof_level: assert property (wrOk && idx == 7'h20 |-> ##2
		oofThreshold == tffc_oof_type'($past(writedata[7:6], 2)))
		else $error("out-of-frame threshold wrong");
	chk_tx_code: assert property (wrOk && idx == 7'h44 |-> ##2
		txB8zs == $past(writedata[5], 2)) else $error("tx line code wrong");
	chk_boc_vote: assert property (wrOk && idx == 7'h2a |-> ##2
		bocFourOfFive == $past(writedata[1], 2)) else $error("boc mode wrong");
	chk_pattern_raw: assert property (wrOk && idx == 7'h3e |=>
		loopActivatePattern == $past(writedata[7:0]))
		else $error("activate pattern not updated");
	cover property (wrOk && idx == 7'h44);
	cover property (read && !waitrequest);
	cover property ($rose(reset_n));
endmodule : tffc_config_monitor

bind tffc_config_bank tffc_config_monitor #(.ADDR_WIDTH(ADDR_WIDTH))
	tffc_config_monitor_inst (
	.mclk(mclk), .reset_n(reset_n), .address(address), .read(read),
	.write(write), .writedata(writedata), .byteenable(byteenable),
	.waitrequest(waitrequest), .rxB8zs(rxB8zs), .txB8zs(txB8zs),
	.bocFourOfFive(bocFourOfFive), .rxFormat(rxFormat),
	.txFormat(txFormat), .oofThreshold(oofThreshold),
	.loopActivatePattern(loopActivatePattern),
	.jitterAttenEnable(jitterAttenEnable),
	.txClockFromBackplane(txClockFromBackplane),
	.diagnosticsEnable(diagnosticsEnable));

/* File: bench/tffc_config_bank_tb.sv */
// Register-access testbench for the framing configuration bank
`timescale 1ns/1ps
module tffc_config_bank_tb;
	import tffc_pkg::*;
	logic mclk, reset_n, read, write, waitrequest;
	logic [8:0] address;
	logic [31:0] writedata, readdata, rdata;
	logic [3:0] byteenable, beSel;
	logic rxB8zs, txB8zs, bocFourOfFive, alarmAltRed, inbandEnable;
	logic robbedBitEnable, jitterAttenEnable, txClockFromBackplane;
	logic diagnosticsEnable, rateMismatch;
	logic [3:0] rxLinkRate, txLinkRate, yellowRate, sigRate;
	logic [7:0] loopActivatePattern, loopDeactivatePattern;
	tffc_format_type rxFormat, txFormat, alarmFormat, sigFormat;
	tffc_oof_type oofThreshold;
	int errorCnt = 0;
	int checkCount = 0;
	logic [6:0] regIdx [9] = '{7'h10, 7'h20, 7'h2a, 7'h2c, 7'h3c, 7'h3e,
		7'h3f, 7'h40, 7'h44};
	logic [7:0] esfVal [9] = '{8'h00, 8'h95, 8'h02, 8'h15, 8'h00, 8'ha5,
		8'h5a, 8'h15, 8'h35};
	logic [7:0] rstVal [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08,
		8'h44, 8'h00, 8'h00};

	tffc_config_bank tffc_config_bank_inst (
		.mclk(mclk), .reset_n(reset_n), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .rxB8zs(rxB8zs),
		.rxFormat(rxFormat), .oofThreshold(oofThreshold),
		.rxLinkRate(rxLinkRate), .txFormat(txFormat), .txB8zs(txB8zs),
		.txLinkRate(txLinkRate), .bocFourOfFive(bocFourOfFive),
		.alarmFormat(alarmFormat), .alarmAltRed(alarmAltRed),
		.yellowRate(yellowRate), .inbandEnable(inbandEnable),
		.loopActivatePattern(loopActivatePattern),
		.loopDeactivatePattern(loopDeactivatePattern),
		.sigFormat(sigFormat), .robbedBitEnable(robbedBitEnable),
		.sigRate(sigRate), .jitterAttenEnable(jitterAttenEnable),
		.txClockFromBackplane(txClockFromBackplane),
		.diagnosticsEnable(diagnosticsEnable), .rateMismatch(rateMismatch)
	);

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	task automatic endSim();
		$display("Checks %0d, errors %0d", checkCount, errorCnt);
		if (errorCnt == 0 && checkCount > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : endSim

	task automatic chk(input string nm, input logic [31:0] e, g);
		checkCount++;
		if (g !== e) begin
			errorCnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic bus(input logic wr, input logic [6:0] idx,
		input logic [7:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		address <= {idx, 2'b00};
		writedata <= {24'h0, d};
		byteenable <= beSel;
		write <= wr;
		read <= !wr;
		do begin
			@(posedge mclk);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		rdata = readdata;
		write <= 1'b0;
		read <= 1'b0;
		if (waitrequest !== 1'b0) begin
			chk("waitrequest", 0, waitrequest);
			endSim();
		end
	endtask : bus

	task automatic rd(input logic [6:0] idx, input logic [7:0] e);
		bus(1'b0, idx, 8'h00);
		chk("readdata", {24'h0, e}, rdata);
	endtask : rd

	// Decoded modes lag the register by one more edge
	task automatic cfg(input logic [7:0] lc, tx, fr, al, sg,
		input logic [13:0] e);
		bus(1'b1, 7'h10, lc);
		bus(1'b1, 7'h44, tx);
		bus(1'b1, 7'h20, fr);
		bus(1'b1, 7'h2c, al);
		bus(1'b1, 7'h40, sg);
		repeat (2) @(negedge mclk);
		chk("modes", e, {rxB8zs, txB8zs, rxFormat,
			txFormat, alarmFormat, sigFormat, oofThreshold, alarmAltRed,
			robbedBitEnable});
	endtask : cfg

	task automatic defaults();
		for (int i = 0; i < 9; i++) rd(regIdx[i], rstVal[i]);
		rd(7'h0d, 8'h03);
		chk("reset modes", 12'h836, {rxB8zs, txB8zs, rxFormat, txFormat,
			jitterAttenEnable, txClockFromBackplane, diagnosticsEnable,
			inbandEnable, robbedBitEnable, rateMismatch});
	endtask : defaults

	initial begin
		reset_n = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = '0;
		writedata = '0;
		byteenable = 4'hf;
		beSel = 4'hf;
		repeat (6) @(posedge mclk);
		reset_n <= 1'b1;
		defaults();
		for (int i = 0; i < 9; i++) bus(1'b1, regIdx[i], esfVal[i]);
		cfg(8'h00, 8'h35, 8'h95, 8'h15, 8'h15, 14'h3ff9);
		chk("rates", 16'h5555, {rxLinkRate, txLinkRate, yellowRate, sigRate});
		chk("patterns", 16'ha55a, {loopActivatePattern,
			loopDeactivatePattern});
		chk("boc inband", 3'b110, {bocFourOfFive, inbandEnable,
			rateMismatch});
		rd(7'h0b, 8'h3f);
		for (int i = 0; i < 9; i++) rd(regIdx[i], esfVal[i]);
		bus(1'b1, 7'h20, 8'h93);
		bus(1'b1, 7'h3c, 8'h01);
		bus(1'b1, 7'h2a, 8'h00);
		repeat (2) @(negedge mclk);
		chk("mismatch inband boc", 3'b100, {rateMismatch, inbandEnable,
			bocFourOfFive});
		cfg(8'h80, 8'h08, 8'h48, 8'h08, 8'h08, 14'h0aa5);
		cfg(8'h80, 8'h0c, 8'h84, 8'h0c, 8'h04, 14'h055a);
		cfg(8'h80, 8'h04, 8'h44, 8'h04, 8'h04, 14'h0554);
		cfg(8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 14'h0001);
		beSel = 4'he;
		bus(1'b1, 7'h3e, 8'h11);
		beSel = 4'hf;
		rd(7'h3e, 8'ha5);
		bus(1'b1, 7'h7f, 8'hff);
		rd(7'h7f, 8'h00);
		bus(1'b1, 7'h0d, 8'h04);
		@(negedge mclk);
		chk("timing", 3'b001, {jitterAttenEnable, txClockFromBackplane,
			diagnosticsEnable});
		bus(1'b1, 7'h0a, 8'h01);
		defaults();
		bus(1'b1, 7'h10, 8'h80);
		bus(1'b1, 7'h0d, 8'h04);
		@(posedge mclk);
		reset_n <= 1'b0;
		repeat (3) @(posedge mclk);
		reset_n <= 1'b1;
		defaults();
		endSim();
	end
endmodule : tffc_config_bank_tb
